// file: logic/bfsg_pkg.sv
// Constants, encodings and carrier types of the boot flash section guard.
package bfsg_pkg;

    // ------------------------------------------------------------------
    // Flash geometry and section boundaries (word addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int WORD_W = 6;
    localparam int PAGE_W = ADDR_W - WORD_W;
    localparam logic [ADDR_W-1:0] NO_READ_WHILE_WRITE_AREA_START = 13'h1c00;
    localparam logic [ADDR_W-1:0] BOOT_START_00 = 13'h1c00;
    localparam logic [ADDR_W-1:0] BOOT_START_01 = 13'h1e00;
    localparam logic [ADDR_W-1:0] BOOT_START_10 = 13'h1f00;
    localparam logic [ADDR_W-1:0] BOOT_START_11 = 13'h1f80;

    // ------------------------------------------------------------------
    // Lock bits (0 = programmed) and reset values
    // ------------------------------------------------------------------
    localparam int LOCK_APP_LOW = 0;
    localparam int LOCK_APP_HIGH = 1;
    localparam int LOCK_BOOT_LOW = 2;
    localparam int LOCK_BOOT_HIGH = 3;
    localparam logic [3:0] LOCK_ERASED = 4'hf;
    localparam logic [1:0] FUSE_RESET = 2'h3;

    // ------------------------------------------------------------------
    // Register map and status fields
    // ------------------------------------------------------------------
    localparam int REG_AW = 2;
    localparam logic [REG_AW-1:0] OFS_CTRL = 2'h0;
    localparam logic [REG_AW-1:0] OFS_STATUS = 2'h1;
    localparam logic [REG_AW-1:0] OFS_LOCK = 2'h2;
    localparam logic [REG_AW-1:0] OFS_FUSE = 2'h3;
    localparam int CTRL_REENABLE = 0;
    localparam int STAT_BUSY_FLAG = 0;
    localparam int STAT_PROG = 1;
    localparam int STAT_HALT = 2;
    localparam int STAT_REFUSED = 3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int PROG_TIME_US = 4000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_LOAD = 2'h0,
        OP_ERASE = 2'h1,
        OP_WRITE = 2'h2,
        OP_LOCK = 2'h3
    } bfsg_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_PROG = 2'h2
    } bfsg_state_t;

    typedef struct packed {
        logic valid;
        bfsg_op_t op;
        logic [ADDR_W-1:0] exec_addr;
        logic [ADDR_W-1:0] z_addr;
        logic [3:0] lock_data;
    } bfsg_spm_req_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] exec_addr;
        logic [ADDR_W-1:0] z_addr;
    } bfsg_lpm_req_t;

    typedef struct packed {
        logic accepted;
        logic refused;
    } bfsg_resp_t;

    typedef struct packed {
        logic start;
        bfsg_op_t op;
        logic [PAGE_W-1:0] page;
    } bfsg_flash_cmd_t;

endpackage : bfsg_pkg

// file: logic/bfsg_guard.sv
// Boot flash section guard: self-programming access, halt and lock control.
`timescale 1ns/1ps

module bfsg_guard #(
    parameter int PROG_CYCLES = bfsg_pkg::PROG_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [bfsg_pkg::REG_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire bfsg_pkg::bfsg_spm_req_t spm_req,
    output bfsg_pkg::bfsg_resp_t spm_resp,
    input wire bfsg_pkg::bfsg_lpm_req_t lpm_req,
    output bfsg_pkg::bfsg_resp_t lpm_resp,
    input wire logic [1:0] boot_size_fuses,
    input wire logic [3:0] lock_nv,
    input wire logic ext_lock_valid,
    input wire logic [3:0] ext_lock_data,
    input wire logic chip_erase,
    input wire logic vectors_in_boot,
    input wire logic [bfsg_pkg::ADDR_W-1:0] core_pc,
    output bfsg_pkg::bfsg_flash_cmd_t flash_cmd,
    output logic core_halt,
    output logic rww_fetch_block,
    output logic irq_disable,
    output logic rw_area_busy_flag
);

    // ------------------------------------------------------------------
    // Section decoding
    // ------------------------------------------------------------------
    // The boot start is never allowed below the fixed area boundary.
    // boot kept high
    function automatic logic [bfsg_pkg::ADDR_W-1:0] boot_start(
        input logic [1:0] fuses
    );
        logic [bfsg_pkg::ADDR_W-1:0] s;
        unique case (fuses)
            2'h0: s = bfsg_pkg::BOOT_START_00;
            2'h1: s = bfsg_pkg::BOOT_START_01;
            2'h2: s = bfsg_pkg::BOOT_START_10;
            2'h3: s = bfsg_pkg::BOOT_START_11;
        endcase
        if (s < bfsg_pkg::NO_READ_WHILE_WRITE_AREA_START) begin
            s = bfsg_pkg::NO_READ_WHILE_WRITE_AREA_START;
        end
        return s;
    endfunction : boot_start

    function automatic logic in_boot(
        input logic [bfsg_pkg::ADDR_W-1:0] addr,
        input logic [bfsg_pkg::ADDR_W-1:0] start
    );
        return addr >= start;
    endfunction : in_boot

    function automatic logic in_rww(
        input logic [bfsg_pkg::ADDR_W-1:0] addr
    );
        return addr < bfsg_pkg::NO_READ_WHILE_WRITE_AREA_START;
    endfunction : in_rww

    localparam logic [bfsg_pkg::CNT_W-1:0] PROG_LAST =
        bfsg_pkg::CNT_W'(PROG_CYCLES - 1);

    bfsg_pkg::bfsg_state_t state_reg;
    logic [bfsg_pkg::CNT_W-1:0] cnt_reg;
    logic [3:0] lock_reg;
    logic lock_loaded_reg;
    logic [1:0] fuse_reg;
    logic target_no_read_while_write_area_reg;
    logic refused_reg;
    logic [bfsg_pkg::ADDR_W-1:0] boot_lo;
    logic spm_from_boot;
    logic spm_to_boot;
    logic spm_prog_op;
    logic spm_ok;
    logic spm_take;
    logic lpm_ok;
    logic reenable_wr;
    logic prog_done;
    logic prog_go;
    logic busy_clear;
    logic pc_in_boot;
    logic [7:0] status_vec;

    // ------------------------------------------------------------------
    // Request decoding
    // ------------------------------------------------------------------
    // Requests are judged in the cycle they arrive; nothing is queued.
    // fuse sizing
    assign boot_lo = boot_start(fuse_reg);
    assign pc_in_boot = in_boot(core_pc, boot_lo);
    assign spm_from_boot = in_boot(spm_req.exec_addr, boot_lo);
    assign spm_to_boot = in_boot(spm_req.z_addr, boot_lo);
    assign spm_prog_op = (spm_req.op == bfsg_pkg::OP_ERASE) ||
                         (spm_req.op == bfsg_pkg::OP_WRITE);
    assign spm_take = spm_req.valid && (state_reg == bfsg_pkg::ST_IDLE);
    assign prog_done = (state_reg == bfsg_pkg::ST_PROG) &&
                       (cnt_reg == PROG_LAST);
    assign reenable_wr = reg_wr && (reg_addr == bfsg_pkg::OFS_CTRL) &&
                         reg_wdata[bfsg_pkg::CTRL_REENABLE];
    assign prog_go = spm_ok && spm_prog_op;
    assign busy_clear = (spm_ok && spm_req.op == bfsg_pkg::OP_LOAD) ||
                        (reenable_wr && state_reg == bfsg_pkg::ST_IDLE);

    // ------------------------------------------------------------------
    // Store-program decision
    // ------------------------------------------------------------------
    // Only the section lock bits are consulted; the chip-wide lock modes
    // are deliberately not an input of this block.
    // chip locks ignored
    always_comb begin
        spm_ok = 1'b0;
        if (spm_take && spm_from_boot) begin
            if (!spm_prog_op) begin
                spm_ok = 1'b1;
            end else if (spm_to_boot) begin
                spm_ok = lock_reg[bfsg_pkg::LOCK_BOOT_LOW];
            end else begin
                spm_ok = lock_reg[bfsg_pkg::LOCK_APP_LOW];
            end
        end
    end

    // ------------------------------------------------------------------
    // Load-program decision
    // ------------------------------------------------------------------
    // Reads follow the busy flag rather than the sequencer, so the area
    // stays shut until software reopens it.
    always_comb begin
        logic from_boot;
        logic to_boot;
        from_boot = in_boot(lpm_req.exec_addr, boot_lo);
        to_boot = in_boot(lpm_req.z_addr, boot_lo);
        lpm_ok = 1'b1;
        if (from_boot && !to_boot &&
            !lock_reg[bfsg_pkg::LOCK_APP_HIGH]) begin
            lpm_ok = 1'b0;
        end
        if (!from_boot && to_boot &&
            !lock_reg[bfsg_pkg::LOCK_BOOT_HIGH]) begin
            lpm_ok = 1'b0;
        end
        if (rw_area_busy_flag && in_rww(lpm_req.z_addr)) begin
            lpm_ok = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // A store request that arrives while programming runs is refused, never
    // held back for later.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= bfsg_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                bfsg_pkg::ST_IDLE: begin
                    if (spm_ok && spm_prog_op) begin
                        state_reg <= bfsg_pkg::ST_PROG;
                    end
                end
                bfsg_pkg::ST_PROG: begin
                    if (prog_done) begin
                        state_reg <= bfsg_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // The counter rests at zero outside programming, so every start runs
    // the full programming time.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else if (state_reg == bfsg_pkg::ST_PROG) begin
            cnt_reg <= cnt_reg + 1'b1;
        end else begin
            cnt_reg <= '0;
        end
    end

    // The page is latched at the start so the core may reuse its pointer.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_cmd <= '0;
            target_no_read_while_write_area_reg <= 1'b0;
        end else begin
            flash_cmd.start <= spm_ok && spm_req.op != bfsg_pkg::OP_LOCK;
            if (spm_ok) begin
                flash_cmd.op <= spm_req.op;
                flash_cmd.page <=
                    spm_req.z_addr[bfsg_pkg::ADDR_W-1:bfsg_pkg::WORD_W];
            end
            if (spm_ok && spm_prog_op) begin
                target_no_read_while_write_area_reg <= !in_rww(spm_req.z_addr);
            end
        end
    end

    // ------------------------------------------------------------------
    // Core control outputs
    // ------------------------------------------------------------------
    // Halt depends on the target page only, never on the running code.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_halt <= 1'b0;
        end else if (prog_go) begin
            core_halt <= !in_rww(spm_req.z_addr);
        end else if (prog_done) begin
            core_halt <= 1'b0;
        end
    end

    // A new programming start in the same cycle as a clear keeps it set.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rw_area_busy_flag <= 1'b0;
        end else if (prog_go) begin
            rw_area_busy_flag <= 1'b1;
        end else if (busy_clear) begin
            rw_area_busy_flag <= 1'b0;
        end
    end

    // Fetch blocking follows the flag; software must clear it itself.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rww_fetch_block <= 1'b0;
        end else if (prog_go) begin
            rww_fetch_block <= 1'b1;
        end else if (busy_clear) begin
            rww_fetch_block <= 1'b0;
        end
    end

    // The mask trails the fetch address by one cycle, so software must not
    // take an interrupt on the first cycle after a section change.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_disable <= 1'b0;
        end else begin
            irq_disable <=
                (!lock_reg[bfsg_pkg::LOCK_APP_HIGH] && vectors_in_boot &&
                 !pc_in_boot) ||
                (!lock_reg[bfsg_pkg::LOCK_BOOT_HIGH] && !vectors_in_boot &&
                 pc_in_boot);
        end
    end

    // ------------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------------
    // A refused store leaves a sticky status bit until status is read.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            spm_resp <= '0;
            lpm_resp <= '0;
            refused_reg <= 1'b0;
        end else begin
            spm_resp.accepted <= spm_ok;
            spm_resp.refused <= spm_req.valid && !spm_ok;
            lpm_resp.accepted <= lpm_req.valid && lpm_ok;
            lpm_resp.refused <= lpm_req.valid && !lpm_ok;
            if (spm_req.valid && !spm_ok) begin
                refused_reg <= 1'b1;
            end else if (reg_rd && reg_addr == bfsg_pkg::OFS_STATUS) begin
                refused_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Lock bits and fuses
    // ------------------------------------------------------------------
    // Lock values are sampled once after reset release, since an asynchronous
    // reset may only load constants; fuse values are resampled every cycle.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_reg <= bfsg_pkg::LOCK_ERASED;
            fuse_reg <= bfsg_pkg::FUSE_RESET;
            lock_loaded_reg <= 1'b0;
        end else begin
            lock_loaded_reg <= 1'b1;
            fuse_reg <= boot_size_fuses;
            if (!lock_loaded_reg) begin
                lock_reg <= lock_nv;
            end else if (chip_erase) begin
                lock_reg <= bfsg_pkg::LOCK_ERASED;
            end else begin
                lock_reg <= lock_reg &
                    (ext_lock_valid ? ext_lock_data : 4'hf) &
                    ((spm_ok && spm_req.op == bfsg_pkg::OP_LOCK) ?
                     spm_req.lock_data : 4'hf) &
                    ((reg_wr && reg_addr == bfsg_pkg::OFS_LOCK) ?
                     reg_wdata[3:0] : 4'hf);
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    // Status bits sit at the positions the package names for them.
    always_comb begin
        status_vec = '0;
        status_vec[bfsg_pkg::STAT_BUSY_FLAG] = rw_area_busy_flag;
        status_vec[bfsg_pkg::STAT_PROG] = state_reg == bfsg_pkg::ST_PROG;
        status_vec[bfsg_pkg::STAT_HALT] = core_halt;
        status_vec[bfsg_pkg::STAT_REFUSED] = refused_reg;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                bfsg_pkg::OFS_CTRL: reg_rdata <= '0;
                bfsg_pkg::OFS_STATUS: reg_rdata <= status_vec;
                bfsg_pkg::OFS_LOCK: reg_rdata <= {4'h0, lock_reg};
                bfsg_pkg::OFS_FUSE: reg_rdata <= {6'h00, fuse_reg};
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule : bfsg_guard

// file: testbench/bfsg_guard_monitor.sv
// Port-level assertions for the boot flash section guard.
`timescale 1ns/1ps

module bfsg_guard_monitor #(
    parameter int PROG_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire bfsg_pkg::bfsg_spm_req_t spm_req,
    input wire bfsg_pkg::bfsg_resp_t spm_resp,
    input wire bfsg_pkg::bfsg_lpm_req_t lpm_req,
    input wire bfsg_pkg::bfsg_resp_t lpm_resp,
    input wire bfsg_pkg::bfsg_flash_cmd_t flash_cmd,
    input wire logic core_halt,
    input wire logic rww_fetch_block,
    input wire logic rw_area_busy_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic prog_start;
    logic rww_page;
    int halt_cnt;

    assign prog_start = flash_cmd.start &&
        (flash_cmd.op == bfsg_pkg::OP_ERASE ||
         flash_cmd.op == bfsg_pkg::OP_WRITE);
    assign rww_page = {flash_cmd.page, 6'h00} < bfsg_pkg::NO_READ_WHILE_WRITE_AREA_START;

    // A halt longer than one programming time would stall the core for good.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            halt_cnt <= 0;
        end else begin
            halt_cnt <= core_halt ? halt_cnt + 1 : 0;
        end
    end

    AST_SPM_ANSWERED: assert property (
        spm_req.valid |=> spm_resp.accepted != spm_resp.refused)
        else $error("store request not answered exactly once");
    AST_APP_SPM_IGNORED: assert property (
        spm_req.valid && spm_req.exec_addr < bfsg_pkg::NO_READ_WHILE_WRITE_AREA_START
        |=> spm_resp.refused && !flash_cmd.start)
        else $error("store request from application was honoured");
    AST_RWW_RUNS: assert property (
        prog_start && rww_page |-> !core_halt && rw_area_busy_flag)
        else $error("wrong halt or busy for read-while-write page");
    AST_NO_READ_WHILE_WRITE_AREA_HALTS: assert property (
        prog_start && !rww_page |-> core_halt [*4])
        else $error("core not halted for no-read-while-write page");
    AST_RWW_BLOCKED: assert property (
        prog_start |-> rww_fetch_block)
        else $error("read-while-write area not blocked");
    AST_HALT_BOUNDED: assert property (
        halt_cnt <= PROG_CYCLES + 2)
        else $error("core halt outlasts programming");
    AST_LPM_BUSY_REFUSED: assert property (
        lpm_req.valid && lpm_req.z_addr < bfsg_pkg::NO_READ_WHILE_WRITE_AREA_START &&
        rw_area_busy_flag |=> lpm_resp.refused)
        else $error("read of busy area not refused");
    AST_LPM_ANSWERED: assert property (
        lpm_req.valid |=> lpm_resp.accepted != lpm_resp.refused)
        else $error("load request not answered exactly once");

    cover property (prog_start && rww_page);
    cover property (prog_start && !rww_page);
    cover property (lpm_resp.refused);
endmodule : bfsg_guard_monitor

// file: testbench/bfsg_core_model.sv
// Processor core model issuing store and load program requests.
`timescale 1ns/1ps

module bfsg_core_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire bfsg_pkg::bfsg_spm_req_t spm_cmd,
    input wire bfsg_pkg::bfsg_lpm_req_t lpm_cmd,
    input wire logic [bfsg_pkg::ADDR_W-1:0] pc_cmd,
    input wire logic core_halt,
    input wire logic rw_area_busy_flag,
    output bfsg_pkg::bfsg_spm_req_t spm_req,
    output bfsg_pkg::bfsg_lpm_req_t lpm_req,
    output logic [bfsg_pkg::ADDR_W-1:0] core_pc
);
    // halted core issues nothing
    // Idle fields toggle so the guard cannot lean on stale values.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            spm_req <= '0;
            lpm_req <= '0;
        end else begin
            spm_req <= bfsg_pkg::bfsg_spm_req_t'(~spm_req);
            lpm_req <= bfsg_pkg::bfsg_lpm_req_t'(~lpm_req);
            spm_req.valid <= 1'b0;
            lpm_req.valid <= 1'b0;
            if (spm_cmd.valid && !core_halt) begin
                spm_req <= spm_cmd;
            end
            if (lpm_cmd.valid && !core_halt) begin
                lpm_req <= lpm_cmd;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_pc <= '0;
        end else if (!(rw_area_busy_flag &&
                       pc_cmd < bfsg_pkg::NO_READ_WHILE_WRITE_AREA_START)) begin
            core_pc <= pc_cmd;
        end
    end
endmodule : bfsg_core_model

// file: testbench/boot_flash_section_guard_tb.sv
// Self-checking bench for the boot flash section guard.
`timescale 1ns/1ps

module boot_flash_section_guard_tb;
    localparam int PROG = 8;
    logic sys_clk;
    logic rst_b;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    bfsg_pkg::bfsg_spm_req_t spm_cmd, spm_req;
    bfsg_pkg::bfsg_lpm_req_t lpm_cmd, lpm_req;
    bfsg_pkg::bfsg_resp_t spm_resp, lpm_resp;
    bfsg_pkg::bfsg_flash_cmd_t flash_cmd;
    logic [1:0] fuses;
    logic [3:0] lock_nv, ext_data, lk;
    logic ext_valid, chip_erase, vib, core_halt, fetch_block, irq_dis, busy;
    logic [12:0] pc_cmd, core_pc;
    logic [7:0] rd;
    logic [1:0] r;
    int fails, cmp_count, n;

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    bfsg_guard #(.PROG_CYCLES(PROG)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .spm_req(spm_req), .spm_resp(spm_resp),
        .lpm_req(lpm_req), .lpm_resp(lpm_resp), .boot_size_fuses(fuses),
        .lock_nv(lock_nv), .ext_lock_valid(ext_valid),
        .ext_lock_data(ext_data), .chip_erase(chip_erase),
        .vectors_in_boot(vib), .core_pc(core_pc), .flash_cmd(flash_cmd),
        .core_halt(core_halt), .rww_fetch_block(fetch_block),
        .irq_disable(irq_dis), .rw_area_busy_flag(busy)
    );

    bfsg_core_model core (
        .sys_clk(sys_clk), .rst_b(rst_b), .spm_cmd(spm_cmd),
        .lpm_cmd(lpm_cmd), .pc_cmd(pc_cmd), .core_halt(core_halt),
        .rw_area_busy_flag(busy), .spm_req(spm_req), .lpm_req(lpm_req),
        .core_pc(core_pc)
    );

    // --------
    // Tasks
    // --------
    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // The model adds one cycle, so the answer lands two edges on.
    task automatic core_req(input logic l, input bfsg_pkg::bfsg_op_t op,
                            input logic [12:0] ex, input logic [12:0] z);
        @(posedge sys_clk);
        if (l) begin
            lpm_cmd <= '{1'b1, ex, z};
        end else begin
            spm_cmd <= '{1'b1, op, ex, z, 4'h0};
        end
        @(posedge sys_clk);
        lpm_cmd.valid <= 1'b0;
        spm_cmd.valid <= 1'b0;
        @(posedge sys_clk);
        #1 r = l ? lpm_resp : spm_resp;
    endtask : core_req

    function automatic logic [12:0] boot_start(input logic [1:0] f);
        case (f)
            2'h0: return bfsg_pkg::BOOT_START_00;
            2'h1: return bfsg_pkg::BOOT_START_01;
            2'h2: return bfsg_pkg::BOOT_START_10;
            default: return bfsg_pkg::BOOT_START_11;
        endcase
    endfunction : boot_start

    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // --------
    // Tests
    // --------
    initial begin
        #(100 * 5000);
        fails++;
        tally_and_finish();
    end

    initial begin
        fails = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        spm_cmd = '0;
        lpm_cmd = '0;
        {fuses, lock_nv} = 6'h3f;
        {ext_valid, ext_data, chip_erase, vib} = '0;
        pc_cmd = 13'h1f80;
        void'($urandom(32'h2d6f));
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reg_read(bfsg_pkg::OFS_LOCK, rd);
        chk("lock reset", rd, 8'h0f);
        reg_write(bfsg_pkg::OFS_FUSE, 8'h00);
        for (int f = 0; f < 4; f++) begin
            @(posedge sys_clk);
            fuses <= f[1:0];
            repeat (2) @(posedge sys_clk);
            reg_read(bfsg_pkg::OFS_FUSE, rd);
            chk("fuse", rd, {6'h00, f[1:0]});
            core_req(0, bfsg_pkg::OP_LOAD, boot_start(f[1:0]) - 13'h1, '0);
            chk("spm below boot", r, 2'b01);
            core_req(0, bfsg_pkg::OP_LOAD, boot_start(f[1:0]), '0);
            chk("spm at boot", r, 2'b10);
        end
        core_req(0, bfsg_pkg::OP_ERASE, 13'h1f80, 13'h0040);
        chk("rww erase", r, 2'b10);
        chk("rww halt", core_halt, 1'b0);
        chk("rww busy", busy, 1'b1);
        reg_write(bfsg_pkg::OFS_CTRL, 8'h01);
        core_req(0, bfsg_pkg::OP_ERASE, 13'h1f80, 13'h0080);
        chk("spm while busy", r, 2'b01);
        repeat (PROG + 4) @(posedge sys_clk);
        reg_read(bfsg_pkg::OFS_STATUS, rd);
        chk("busy kept", rd[0], 1'b1);
        core_req(1, bfsg_pkg::OP_LOAD, 13'h1f80, 13'h0100);
        chk("rww read blocked", r, 2'b01);
        reg_write(bfsg_pkg::OFS_CTRL, 8'h01);
        #1 chk("busy reenable", busy, 1'b0);
        core_req(1, bfsg_pkg::OP_LOAD, 13'h1f80, 13'h0100);
        chk("rww read open", r, 2'b10);
        core_req(0, bfsg_pkg::OP_WRITE, 13'h1f80, 13'h0040);
        repeat (PROG + 4) @(posedge sys_clk);
        core_req(0, bfsg_pkg::OP_LOAD, 13'h1f80, 13'h0000);
        chk("busy page load", busy, 1'b0);
        core_req(0, bfsg_pkg::OP_WRITE, 13'h1f80, 13'h1c40);
        chk("no_read_while_write_area halt", core_halt, 1'b1);
        n = 0;
        while (core_halt && n < 100) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk("halt span", 16'(n), 16'(PROG));
        for (int i = 0; i < 8; i++) begin
            lk = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($urandom);
            @(posedge sys_clk);
            chip_erase <= 1'b1;
            @(posedge sys_clk);
            chip_erase <= 1'b0;
            ext_valid <= 1'b1;
            ext_data <= lk;
            @(posedge sys_clk);
            ext_valid <= 1'b0;
            reg_write(bfsg_pkg::OFS_LOCK, 8'hff);
            reg_read(bfsg_pkg::OFS_LOCK, rd);
            chk("lock bits", rd, {4'h0, lk});
            core_req(0, bfsg_pkg::OP_WRITE, 13'h1f80, 13'h0100);
            chk("app write", r, lk[0] ? 2'b10 : 2'b01);
            repeat (PROG + 4) @(posedge sys_clk);
            reg_write(bfsg_pkg::OFS_CTRL, 8'h01);
            core_req(0, bfsg_pkg::OP_ERASE, 13'h1f80, 13'h1fc0);
            chk("boot erase", r, lk[2] ? 2'b10 : 2'b01);
            repeat (PROG + 4) @(posedge sys_clk);
            reg_write(bfsg_pkg::OFS_CTRL, 8'h01);
            core_req(1, bfsg_pkg::OP_LOAD, 13'h1f80, 13'h0100);
            chk("boot reads app", r, lk[1] ? 2'b10 : 2'b01);
            core_req(1, bfsg_pkg::OP_LOAD, 13'h0040, 13'h1fc0);
            chk("app reads boot", r, lk[3] ? 2'b10 : 2'b01);
            @(posedge sys_clk);
            vib <= 1'b1;
            pc_cmd <= 13'h0040;
            repeat (4) @(posedge sys_clk);
            #1 chk("irq in app", irq_dis, !lk[1]);
            @(posedge sys_clk);
            vib <= 1'b0;
            pc_cmd <= 13'h1f80;
            repeat (4) @(posedge sys_clk);
            #1 chk("irq in boot", irq_dis, !lk[3]);
        end
        tally_and_finish();
    end
endmodule : boot_flash_section_guard_tb

bind bfsg_guard bfsg_guard_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon (
    .sys_clk(sys_clk), .rst_b(rst_b), .spm_req(spm_req),
    .spm_resp(spm_resp), .lpm_req(lpm_req), .lpm_resp(lpm_resp),
    .flash_cmd(flash_cmd), .core_halt(core_halt),
    .rww_fetch_block(rww_fetch_block),
    .rw_area_busy_flag(rw_area_busy_flag)
);
